// File: src/sgc_regs.svh
// Purpose: offsets, field positions and reset values of the global
//          switch control bank (clock select, 802.1p map, unknown
//          destination forwarding, PHY management address).
// Assumes: byte-wide registers on the documented host register port.
// Notes:   reserved fields read back their constant values.
`ifndef SGC_REGS_SVH
`define SGC_REGS_SVH

// register offsets on the host register port
`define SGC_OFF_CLK_SEL     8'h0B
`define SGC_OFF_MAP_LOW     8'h0C
`define SGC_OFF_MAP_HIGH    8'h0D
`define SGC_OFF_UNK_FWD     8'h0E
`define SGC_OFF_PHY_ADDR    8'h0F

// field positions
`define SGC_CLK_SEL_LSB     6
`define SGC_UNK_EN_BIT      7
`define SGC_PAD_DRV_BIT     6
`define SGC_PHY_ADDR_LSB    3

// reset values of the writable fields
`define SGC_CLK_SEL_RST     2'h2
`define SGC_MAP_LOW_RST     8'h50
`define SGC_MAP_HIGH_RST    8'hFA
`define SGC_UNK_EN_RST      1'h0
`define SGC_PAD_DRV_RST     1'h1
`define SGC_UNK_MASK_RST    3'h7
`define SGC_PHY_ADDR_RST    5'h01
`define SGC_PHY_ADDR_STEP   5'h01

// constant read values of the reserved fields
`define SGC_CLK_RSVD_VAL    6'h08
`define SGC_UNK_RSVD_VAL    3'h0
`define SGC_PHY_RSVD_VAL    3'h0

// illegal codes
`define SGC_CLK_SEL_BAD     2'h3
`define SGC_PHY_BAD_ZERO    5'h00
`define SGC_PHY_BAD_HI0     5'h1E
`define SGC_PHY_BAD_HI1     5'h1F

`endif

// File: src/sgc_pkg.sv
// Purpose: types and shared decode functions of the global control bank.
// Assumes: constants come from sgc_regs.svh.
// Notes:   functions are used by the bank, the lookup and the checks.
`default_nettype none
`include "sgc_regs.svh"

package sgc_pkg;

    // host interface clock choices
    typedef enum logic [1:0] {
        SGC_CLK_31M25 = 2'h0,
        SGC_CLK_62M5  = 2'h1,
        SGC_CLK_125M  = 2'h2
    } sgc_clk_sel_type;

    typedef logic [1:0] sgc_prio_type;

    // pick the two-bit map field for a priority code point
    function automatic sgc_prio_type sgc_prio_of(input logic [15:0] map,
                                                 input logic [2:0]  pcp);
        sgc_prio_type result;
        result = map[{pcp, 1'b0} +: 2];
        return result;
    endfunction

    // a PHY address code the hardware accepts
    function automatic logic sgc_phy_code_ok(input logic [4:0] code);
        logic ok;
        ok = (code != `SGC_PHY_BAD_ZERO) && (code != `SGC_PHY_BAD_HI0) &&
             (code != `SGC_PHY_BAD_HI1);
        return ok;
    endfunction

endpackage

`default_nettype wire

// File: src/sgc_map_if.sv
// Purpose: carries the 802.1p map and the lookup request between the
//          register bank and the priority lookup.
// Assumes: one clock domain, owned by the modules.
// Notes:   no clocking block.
`timescale 1ns/100ps
`default_nettype none

interface sgc_map_if;
    logic [15:0] prio_map;
    logic        tag_valid;
    logic [2:0]  tag_pcp;
    logic [1:0]  int_prio;
    logic        int_prio_valid;

    modport bank   (output prio_map, tag_valid, tag_pcp,
                    input  int_prio, int_prio_valid);
    modport lookup (input  prio_map, tag_valid, tag_pcp,
                    output int_prio, int_prio_valid);
endinterface

`default_nettype wire

// File: src/sgc_prio_lookup.sv
// Purpose: turns a received 802.1p code point into the internal queue.
// Assumes: tag_valid marks a tagged frame for one cycle.
// Notes:   one cycle latency; result holds until the next tagged frame.
`timescale 1ns/100ps
`default_nettype none

module sgc_prio_lookup
    import sgc_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst_n,
    sgc_map_if.lookup     map
);

    ////////////////////////////////////////////////////////////////////
    // registered lookup, so the queue value is glitch free downstream
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            map.int_prio       <= 2'h0;
            map.int_prio_valid <= 1'b0;
        end else begin
            map.int_prio_valid <= map.tag_valid;
            if (map.tag_valid) begin
                map.int_prio <= sgc_prio_of(map.prio_map, map.tag_pcp);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_prio_lookup;
        @(posedge clk) disable iff (!rst_n)
        map.tag_valid |=> map.int_prio_valid &&
            map.int_prio == sgc_prio_of($past(map.prio_map),
                                        $past(map.tag_pcp));
    endproperty
    a_prio_lookup: assert property (p_prio_lookup)
        else $error("internal priority does not match map field");

endmodule

`default_nettype wire

// File: src/sgc_global_regs.sv
// Purpose: global control bank: host clock select, 802.1p remap,
//          unknown destination forwarding, pad drive, PHY address.
// Assumes: reg_wr and reg_rd are one-cycle strobes from the host port.
// Notes:   read data is registered and appears one cycle after reg_rd.
`timescale 1ns/100ps
`default_nettype none
`include "sgc_regs.svh"

module sgc_global_regs
    import sgc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic      [1:0] host_clk_sel,
    input  wire logic       tag_valid,
    input  wire logic [2:0] tag_pcp,
    output logic      [1:0] int_prio,
    output logic            int_prio_valid,
    input  wire logic       dest_unknown,
    input  wire logic [2:0] flood_ports,
    output logic      [2:0] fwd_ports,
    output logic            fwd_valid,
    output logic            pad_drive_16ma,
    output logic      [4:0] phy1_addr,
    output logic      [4:0] phy2_addr
);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic [7:0] map_low;
    logic [7:0] map_high;
    logic       unk_en;
    logic [2:0] unk_mask;

    ////////////////////////////////////////////////////////////////////
    // write decode; illegal codes are dropped so the field stays usable
    wire        wr_clk   = reg_wr && (reg_addr == `SGC_OFF_CLK_SEL);
    wire        wr_low   = reg_wr && (reg_addr == `SGC_OFF_MAP_LOW);
    wire        wr_high  = reg_wr && (reg_addr == `SGC_OFF_MAP_HIGH);
    wire        wr_unk   = reg_wr && (reg_addr == `SGC_OFF_UNK_FWD);
    wire        wr_phy   = reg_wr && (reg_addr == `SGC_OFF_PHY_ADDR);
    wire [1:0]  wr_clk_code = reg_wdata[`SGC_CLK_SEL_LSB +: 2];
    wire [4:0]  wr_phy_code = reg_wdata[`SGC_PHY_ADDR_LSB +: 5];
    wire        clk_code_ok = (wr_clk_code != `SGC_CLK_SEL_BAD);
    wire        phy_code_ok = sgc_phy_code_ok(wr_phy_code);

    ////////////////////////////////////////////////////////////////////
    // clock select and PHY address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_clk_sel <= `SGC_CLK_SEL_RST;
            phy1_addr    <= `SGC_PHY_ADDR_RST;
            phy2_addr    <= `SGC_PHY_ADDR_RST + `SGC_PHY_ADDR_STEP;
        end else begin
            if (wr_clk && clk_code_ok) begin
                host_clk_sel <= wr_clk_code;
            end
            if (wr_phy && phy_code_ok) begin
                phy1_addr <= wr_phy_code;
                phy2_addr <= wr_phy_code + `SGC_PHY_ADDR_STEP;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // priority map and forwarding controls; reserved bits never stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            map_low        <= `SGC_MAP_LOW_RST;
            map_high       <= `SGC_MAP_HIGH_RST;
            unk_en         <= `SGC_UNK_EN_RST;
            pad_drive_16ma <= `SGC_PAD_DRV_RST;
            unk_mask       <= `SGC_UNK_MASK_RST;
        end else begin
            if (wr_low) begin
                map_low <= reg_wdata;
            end
            if (wr_high) begin
                map_high <= reg_wdata;
            end
            if (wr_unk) begin
                unk_en         <= reg_wdata[`SGC_UNK_EN_BIT];
                pad_drive_16ma <= reg_wdata[`SGC_PAD_DRV_BIT];
                unk_mask       <= reg_wdata[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux: stored fields plus constant reserved values
    wire [7:0] rd_clk  = {host_clk_sel, `SGC_CLK_RSVD_VAL};
    wire [7:0] rd_unk  = {unk_en, pad_drive_16ma, `SGC_UNK_RSVD_VAL,
                          unk_mask};
    wire [7:0] rd_phy  = {phy1_addr, `SGC_PHY_RSVD_VAL};
    wire [7:0] next_rdata =
        (reg_addr == `SGC_OFF_CLK_SEL)  ? rd_clk   :
        (reg_addr == `SGC_OFF_MAP_LOW)  ? map_low  :
        (reg_addr == `SGC_OFF_MAP_HIGH) ? map_high :
        (reg_addr == `SGC_OFF_UNK_FWD)  ? rd_unk   :
        (reg_addr == `SGC_OFF_PHY_ADDR) ? rd_phy   : 8'h00;

    // data holds between reads so a slow host port can sample late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // unknown destination steering; disabled means normal flooding
    wire [2:0] next_fwd_ports = unk_en ? unk_mask : flood_ports;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_ports <= 3'h0;
            fwd_valid <= 1'b0;
        end else begin
            fwd_valid <= dest_unknown;
            if (dest_unknown) begin
                fwd_ports <= next_fwd_ports;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // priority lookup on the map, low register holds code points 0-3
    sgc_map_if map_bus ();

    assign map_bus.prio_map  = {map_high, map_low};
    assign map_bus.tag_valid = tag_valid;
    assign map_bus.tag_pcp   = tag_pcp;
    assign int_prio          = map_bus.int_prio;
    assign int_prio_valid    = map_bus.int_prio_valid;

    sgc_prio_lookup u_lookup (
        .clk   (clk),
        .rst_n (rst_n),
        .map   (map_bus.lookup)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_wr_unk;
        reg_wr && reg_addr == `SGC_OFF_UNK_FWD;
    endsequence

    sequence s_rd_unk;
        reg_rd && reg_addr == `SGC_OFF_UNK_FWD;
    endsequence

    property p_clk_sel;
        wr_clk && clk_code_ok |=> host_clk_sel == $past(wr_clk_code);
    endproperty
    a_clk_sel: assert property (p_clk_sel)
        else $error("clock select not taken from write");

    property p_clk_bad;
        wr_clk && !clk_code_ok |=> $stable(host_clk_sel);
    endproperty
    a_clk_bad: assert property (p_clk_bad)
        else $error("illegal clock code changed select");

    property p_map_order;
        tag_valid && tag_pcp[2] |=> int_prio ==
            $past(map_high[{tag_pcp[1:0], 1'b0} +: 2]);
    endproperty
    a_map_order: assert property (p_map_order)
        else $error("upper code points not mapped from high register");

    property p_unk_steer;
        dest_unknown && unk_en |=> fwd_valid &&
            fwd_ports == $past(unk_mask);
    endproperty
    a_unk_steer: assert property (p_unk_steer)
        else $error("unknown destination not steered to mask");

    property p_unk_off;
        dest_unknown && !unk_en |=> fwd_ports == $past(flood_ports);
    endproperty
    a_unk_off: assert property (p_unk_off)
        else $error("disabled steering altered flood ports");

    property p_phy_bad;
        wr_phy && !phy_code_ok |=> $stable(phy1_addr);
    endproperty
    a_phy_bad: assert property (p_phy_bad)
        else $error("invalid PHY code was accepted");

    property p_phy_pair;
        phy2_addr == phy1_addr + `SGC_PHY_ADDR_STEP;
    endproperty
    a_phy_pair: assert property (p_phy_pair)
        else $error("second PHY address not first plus one");

    property p_pad_drive;
        s_wr_unk |=> pad_drive_16ma == $past(reg_wdata[6]);
    endproperty
    a_pad_drive: assert property (p_pad_drive)
        else $error("pad drive bit not written");

    property p_readback;
        s_wr_unk ##1 s_rd_unk |=>
            reg_rdata == {$past(reg_wdata, 2) & 8'hC7};
    endproperty
    a_readback: assert property (p_readback)
        else $error("readback differs from write with reserved zero");

    property p_rsvd_clk;
        reg_rd && reg_addr == `SGC_OFF_CLK_SEL |=>
            reg_rdata[5:0] == `SGC_CLK_RSVD_VAL;
    endproperty
    a_rsvd_clk: assert property (p_rsvd_clk)
        else $error("reserved clock select bits read wrong");

endmodule

`default_nettype wire

// File: test/test_switch_global_control_regs.sv
// Purpose: self-checking bench for the global switch control bank.
// Assumes: strobes taken at the rising edge, answers one cycle later.
// Notes:   outputs are sampled at the falling edge, once settled.
`timescale 1ns/100ps
`default_nettype none

module test_switch_global_control_regs
    import sgc_pkg::*;
;
    logic       clk;
    logic       rst_n;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [1:0] host_clk_sel;
    logic       tag_valid;
    logic [2:0] tag_pcp;
    logic [1:0] int_prio;
    logic       int_prio_valid;
    logic       dest_unknown;
    logic [2:0] flood_ports;
    logic [2:0] fwd_ports;
    logic       fwd_valid;
    logic       pad_drive_16ma;
    logic [4:0] phy1_addr;
    logic [4:0] phy2_addr;
    int         failures;
    int         samples_checked;

    sgc_global_regs u_dut (
        .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .host_clk_sel(host_clk_sel), .tag_valid(tag_valid),
        .tag_pcp(tag_pcp), .int_prio(int_prio),
        .int_prio_valid(int_prio_valid), .dest_unknown(dest_unknown),
        .flood_ports(flood_ports), .fwd_ports(fwd_ports),
        .fwd_valid(fwd_valid), .pad_drive_16ma(pad_drive_16ma),
        .phy1_addr(phy1_addr), .phy2_addr(phy2_addr)
    );

    ////////////////////////////////////////////////////////////////////////
    // 10 MHz core clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // compare tasks: register bytes and port outputs
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: port %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("failures %0d samples_checked %0d", failures,
                 samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // register port cycles; effects are looked at after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        chk_reg(reg_rdata, exp);
    endtask

    // hold reset low for two cycles; called once, to reset in mid-run
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        chk_out(8'(host_clk_sel), 8'h02);
        chk_out(8'(pad_drive_16ma), 8'h01);
        chk_out(8'(phy1_addr), 8'h01);
        chk_out(8'(phy2_addr), 8'h02);
        rd(8'h0B, 8'h88);
        rd(8'h0C, 8'h50);
        rd(8'h0D, 8'hFA);
        rd(8'h0E, 8'h47);
        rd(8'h0F, 8'h08);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
    endtask

    // every code, the refused code 11, and reserved bits written high
    task automatic t_clock_select();
        wr(8'h0B, 8'h00);
        chk_out(8'(host_clk_sel), 8'h00);
        rd(8'h0B, 8'h08);
        wr(8'h0B, 8'h7F);
        chk_out(8'(host_clk_sel), 8'h01);
        rd(8'h0B, 8'h48);
        wr(8'h0B, 8'hC8);
        chk_out(8'(host_clk_sel), 8'h01);
        wr(8'h0B, 8'h88);
        chk_out(8'(host_clk_sel), 8'h02);
    endtask

    // back-to-back tagged frames sweep all eight code points
    task automatic t_prio_sweep(input logic [15:0] map);
        logic [1:0] exp;
        for (int i = 0; i <= 8; i++) begin
            @(posedge clk);
            tag_valid <= (i < 8);
            tag_pcp   <= i[2:0];
            @(negedge clk);
            if (i > 0) begin
                exp = map[2 * (i - 1) +: 2];
                chk_out(8'(int_prio_valid), 8'h01);
                chk_out(8'(int_prio), 8'(exp));
            end
        end
        @(negedge clk);
        chk_out(8'(int_prio_valid), 8'h00);
    endtask

    // one frame of unknown destination, then the pulse must end
    task automatic fwd_check(input logic [2:0] f, input logic [2:0] exp);
        @(posedge clk);
        dest_unknown <= 1'b1;
        flood_ports  <= f;
        @(posedge clk);
        dest_unknown <= 1'b0;
        @(negedge clk);
        chk_out(8'(fwd_valid), 8'h01);
        chk_out(8'(fwd_ports), 8'(exp));
        @(negedge clk);
        chk_out(8'(fwd_valid), 8'h00);
    endtask

    task automatic t_unknown_dest();
        fwd_check(3'h3, 3'h3);
        wr(8'h0E, 8'h85);
        chk_out(8'(pad_drive_16ma), 8'h00);
        rd(8'h0E, 8'h85);
        fwd_check(3'h3, 3'h5);
        wr(8'h0E, 8'h3A);
        rd(8'h0E, 8'h02);
        fwd_check(3'h6, 3'h6);
    endtask

    // write then read in the next cycle, then both strobes together;
    // a read taken with a write returns the value before that write
    task automatic t_back_to_back();
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= 8'h0E;
        reg_wdata <= 8'hFF;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk);
        reg_rd    <= 1'b0;
        @(negedge clk);
        chk_reg(reg_rdata, 8'hC7);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b1;
        reg_wdata <= 8'h01;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        @(negedge clk);
        chk_reg(reg_rdata, 8'hC7);
        chk_out(8'(pad_drive_16ma), 8'h00);
        rd(8'h0E, 8'h01);
    endtask

    // highest legal address, then each invalid code is ignored
    task automatic t_phy_addr();
        logic [7:0] bad [3];
        bad = '{8'hF0, 8'hF8, 8'h00};
        wr(8'h0F, 8'hEF);
        chk_out(8'(phy1_addr), 8'h1D);
        chk_out(8'(phy2_addr), 8'h1E);
        rd(8'h0F, 8'hE8);
        foreach (bad[k]) begin
            wr(8'h0F, bad[k]);
            chk_out(8'(phy1_addr), 8'h1D);
            chk_out(8'(phy2_addr), 8'h1E);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #500000;
        failures++;
        test_done();
    end

    // main sequence; inputs get values at time zero
    initial begin
        failures        = 0;
        samples_checked = 0;
        rst_n        = 1'b0;
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        reg_addr     = 8'h00;
        reg_wdata    = 8'h00;
        tag_valid    = 1'b0;
        tag_pcp      = 3'h0;
        dest_unknown = 1'b0;
        flood_ports  = 3'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        t_reset_values();
        t_prio_sweep(16'hFA50);
        wr(8'h0C, 8'hE4);
        wr(8'h0D, 8'h1B);
        t_prio_sweep(16'h1BE4);
        t_clock_select();
        t_unknown_dest();
        t_back_to_back();
        t_phy_addr();
        do_reset();
        t_reset_values();
        test_done();
    end
endmodule

`default_nettype wire
